// ---- logic/ldcfg_top.sv ----
// Second configuration register bank with section timing and switch-on shift
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ldcfg_consts.svh"

// What this block does
// - Bit 15 picks rise slew: 0 fast about 15ns, 1 slow about 60ns.
// - Bit 14 picks fall slew: 0 fast about 15ns, 1 slow about 60ns.
// - Shift code zero leaves every channel switch-on instant unmoved.
// - Codes 1-5 delay switch-on that many clocks, 6 gives 5, only for 1-4 on-time.
// - Single refresh, 14-bit: 16384-clock cycle in 32 sections of 512.
// - Single refresh, 13-bit: 8192-clock cycle in 16 sections of 512.
// - Double refresh, 14-bit: 16384-clock cycle in 64 sections of 256.
// - Double refresh, 13-bit: 8192-clock cycle in 32 sections of 256.
// - Bit 8 set enables first low-gray compensation; clear disables it.
// - Register resets to all zeros so every field starts at default.
module ldcfg_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             output_rise_slew_select,
  output logic             output_fall_slew_select,
  output logic             low_gray_comp1_en,
  output logic             section_start,
  output logic [5:0]       section_index,
  output logic [13:0]      pwm_position,
  output logic             probe_channel_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Switch-on delay in grayscale clocks for a given code and on-time
  function automatic logic [2:0] shift_of(input logic [2:0]  code,
                                          input logic [13:0] on_time);
    logic [2:0] d;
    d = 3'h0;
    if (on_time != 14'h0000 && on_time <= `LDCFG_SHORT_ON_MAX) begin
      // Code 7 is undocumented; clamp it like code 6 to the largest shift
      d = (code > `LDCFG_SHIFT_MAX) ? `LDCFG_SHIFT_MAX : code;
    end
    if (code == 3'h0) begin
      d = 3'h0;
    end
    return d;
  endfunction

  // Log2 of section length from the refresh mode
  function automatic logic [3:0] sect_log(input logic dbl);
    return dbl ? `LDCFG_SECT_LOG_DOUBLE : `LDCFG_SECT_LOG_SINGLE;
  endfunction

  // Merge a write word into an old value under byte strobes
  function automatic logic [15:0] strobe_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus state

  ldcfg_pkg::ldcfg_cfg2_t   cfg2;
  ldcfg_pkg::ldcfg_status_t status;
  logic                     depth_select_bit;
  logic [13:0]              probe_on_time;
  logic                     aw_held;
  logic [3:0]               aw_addr;
  logic                     w_held;
  logic [31:0]              w_data;
  logic [3:0]               w_strb;
  logic                     do_write;
  logic [3:0]               gclk_div;
  logic                     gclk_en;
  logic [14:0]              cycle_len;
  logic [14:0]              pos;
  logic [14:0]              next_pos;
  logic [3:0]               slog;
  logic [2:0]               delay;
  logic [15:0]              cfg2_merged;
  logic [15:0]              probe_merged;
  logic [31:0]              rd_word;

  // A write fires once both halves are held and no response is pending
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data capture, taken in either order

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  // Data channel mirrors the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only targets answer with slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LDCFG_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == `LDCFG_OFS_STATUS || aw_addr[1:0] != 2'h0) ?
                      `LDCFG_RESP_SLVERR : `LDCFG_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  assign cfg2_merged = strobe_merge(cfg2, w_data, w_strb);
  // Probe word is only 14 bits; top two bits of the merge are dropped on store
  assign probe_merged = strobe_merge({2'h0, probe_on_time}, w_data, w_strb);

  // Only documented fields store; reserved and out-of-scope bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg2 <= `LDCFG_CFG2_RESET;
    end else if (do_write && aw_addr == `LDCFG_OFS_CFG2) begin
      cfg2 <= cfg2_merged & `LDCFG_CFG2_WMASK;
    end
  end

  // Depth bit, mirror of the first register's grayscale depth select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth_select_bit <= `LDCFG_DEPTH_RESET;
    end else if (do_write && aw_addr == `LDCFG_OFS_DEPTH && w_strb[0]) begin
      depth_select_bit <= w_data[0];
    end
  end

  // On-time of the probe channel, used to exercise the switch-on shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_on_time <= `LDCFG_PROBE_RESET;
    end else if (do_write && aw_addr == `LDCFG_OFS_PROBE) begin
      probe_on_time <= probe_merged[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  // Read word decode; bits above each register's width read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `LDCFG_OFS_CFG2:   rd_word = {16'h0000, cfg2};
      `LDCFG_OFS_DEPTH:  rd_word = {31'h0000_0000, depth_select_bit};
      `LDCFG_OFS_PROBE:  rd_word = {18'h00000, probe_on_time};
      `LDCFG_OFS_STATUS: rd_word = {16'h0000, status};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // One read in flight; arready only while no data is waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LDCFG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (s_axi_araddr[1:0] != 2'h0) ? `LDCFG_RESP_SLVERR : `LDCFG_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grayscale clock enable

  // Divider gives a one-cycle grayscale tick; avoids a second clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gclk_div <= 4'h0;
      gclk_en  <= 1'b0;
    end else begin
      gclk_en  <= (gclk_div == `LDCFG_GCLK_DIV - 4'h1);
      gclk_div <= (gclk_div == `LDCFG_GCLK_DIV - 4'h1) ? 4'h0 : gclk_div + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM cycle and section timing

  // 13-bit depth halves the cycle; the top position bit simply stays zero
  assign cycle_len = depth_select_bit ? `LDCFG_CYCLE_13 : `LDCFG_CYCLE_14;
  assign slog      = sect_log(cfg2.double_refresh);
  assign next_pos  = (pos + 15'h0001 >= cycle_len) ? 15'h0000 : pos + 15'h0001;
  assign delay     = shift_of(cfg2.channel_switch_on_shift, probe_on_time);

  // Position in the cycle; a depth change mid-cycle wraps on the next tick only if the position is past the new end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos <= 15'h0000;
    end else if (gclk_en) begin
      pos <= next_pos;
    end
  end

  // Section boundary pulse and index; one tick per section start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      section_start <= 1'b0;
      section_index <= 6'h00;
      pwm_position  <= 14'h0000;
    end else begin
      section_start <= gclk_en && ((next_pos & ((15'h0001 << slog) - 15'h0001)) == 15'h0000);
      if (gclk_en) begin
        section_index <= 6'((next_pos >> slog) & 15'h003f);
        pwm_position  <= next_pos[13:0];
      end
    end
  end

  // Status word: geometry of the cycle and the active shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status.section_count   <= 6'((cycle_len >> slog) - 15'h0001);
      status.section_index   <= section_index;
      status.depth_13        <= depth_select_bit;
      status.switch_on_delay <= delay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel drive controls

  // Slew picks go to the output stage as plain levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_rise_slew_select <= 1'b0;
      output_fall_slew_select <= 1'b0;
      low_gray_comp1_en       <= 1'b0;
    end else begin
      output_rise_slew_select <= cfg2.rise_slow;
      output_fall_slew_select <= cfg2.fall_slow;
      low_gray_comp1_en       <= cfg2.low_gray_comp1;
    end
  end

  // Probe channel: on from the shifted start for its requested on-time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_channel_on <= 1'b0;
    end else if (gclk_en) begin
      probe_channel_on <= (next_pos >= {12'h000, delay}) &&
                          (next_pos < {1'b0, probe_on_time} + {12'h000, delay});
    end
  end

endmodule

// ---- logic/ldcfg_consts.svh ----
// Offsets, field positions, reset values and timing counts of the config register bank
`ifndef LDCFG_CONSTS_SVH
`define LDCFG_CONSTS_SVH

`define LDCFG_OFS_CFG2        4'h0
`define LDCFG_OFS_DEPTH       4'h4
`define LDCFG_OFS_PROBE       4'h8
`define LDCFG_OFS_STATUS      4'hc

`define LDCFG_CFG2_RESET      16'h0000
`define LDCFG_CFG2_WMASK      16'hfd00
`define LDCFG_DEPTH_RESET     1'b0
`define LDCFG_PROBE_RESET     14'h0000

`define LDCFG_BIT_RISE        15
`define LDCFG_BIT_FALL        14
`define LDCFG_SHIFT_HI        13
`define LDCFG_SHIFT_LO        11
`define LDCFG_BIT_DBL         10
`define LDCFG_BIT_LG1         8

`define LDCFG_FAST_SLEW_NS    15
`define LDCFG_SLOW_SLEW_NS    60

`define LDCFG_CYCLE_14        15'h4000
`define LDCFG_CYCLE_13        15'h2000
`define LDCFG_SECT_LOG_SINGLE 4'h9
`define LDCFG_SECT_LOG_DOUBLE 4'h8
`define LDCFG_SHIFT_MAX       3'h5
`define LDCFG_SHORT_ON_MAX    14'h0004
`define LDCFG_GCLK_DIV        4'h2

`define LDCFG_RESP_OKAY       2'h0
`define LDCFG_RESP_SLVERR     2'h2

`endif

// ---- logic/ldcfg_pkg.sv ----
// Types shared by the config register bank
package ldcfg_pkg;

  typedef struct packed {
    logic       rise_slow;
    logic       fall_slow;
    logic [2:0] channel_switch_on_shift;
    logic       double_refresh;
    logic       rsv9;
    logic       low_gray_comp1;
    logic       rsv7;
    logic [6:0] lower;
  } ldcfg_cfg2_t;

  typedef struct packed {
    logic [5:0] section_count;
    logic [5:0] section_index;
    logic       depth_13;
    logic [2:0] switch_on_delay;
  } ldcfg_status_t;

endpackage

// ---- sim/ldcfg_host.sv ----
// Register bus master standing in for the display controller
`timescale 1ns/1ns
module ldcfg_host (
  input  wire logic        aclk,
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [3:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Bus idle at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  //////////////////////////////
  // Both halves offered at once; each dropped on its own handshake
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] s = 4'hf);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok |= s_axi_awvalid && s_axi_awready;
      w_ok |= s_axi_wvalid && s_axi_wready;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read data taken at the edge that shows rvalid
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ---- sim/ldcfg_top_props.sv ----
// Property checker for the config register bank
`timescale 1ns/1ns
module ldcfg_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        output_rise_slew_select,
  input wire logic        output_fall_slew_select,
  input wire logic        low_gray_comp1_en,
  input wire logic        section_start,
  input wire logic [5:0]  section_index,
  input wire logic [13:0] pwm_position
);
  logic [3:0]  wa;
  logic [31:0] wd;
  // Last write address and data taken
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd <= s_axi_wdata;
    end
  end
  //////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Outputs lag the store by a cycle, so allow two
  AST_RISE: assert property (
    $rose(s_axi_bvalid) && wa == 4'h0 |-> ##[1:2] output_rise_slew_select == wd[15])
    else $error("rise slew wrong");
  AST_FALL: assert property (
    $rose(s_axi_bvalid) && wa == 4'h0 |-> ##[1:2] output_fall_slew_select == wd[14])
    else $error("fall slew wrong");
  AST_LG1: assert property (
    $rose(s_axi_bvalid) && wa == 4'h0 |-> ##[1:2] low_gray_comp1_en == wd[8])
    else $error("low gray enable wrong");
  AST_RST: assert property (
    $rose(aresetn) |-> !output_rise_slew_select && !output_fall_slew_select
      && !low_gray_comp1_en && pwm_position == 14'h0000)
    else $error("reset value wrong");
  AST_SECT: assert property (
    section_start |-> pwm_position[7:0] == 8'h00) else $error("section edge off");
  AST_IDX0: assert property (
    section_start && pwm_position == 14'h0000 |-> section_index == 6'h00)
    else $error("first section index wrong");
  AST_STEP: assert property (
    $changed(pwm_position) |-> pwm_position == $past(pwm_position) + 14'h0001
      || pwm_position == 14'h0000) else $error("position step wrong");
  AST_HOLD: assert property (
    $changed(pwm_position) |=> $stable(pwm_position)) else $error("tick too fast");
endmodule
bind ldcfg_top ldcfg_top_props chk (.*);

// ---- sim/led_driver_config_two_upper_tb.sv ----
// Self-checking bench for the config register bank
`timescale 1ns/1ns
module led_driver_config_two_upper_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        output_rise_slew_select, output_fall_slew_select, low_gray_comp1_en;
  logic        section_start, probe_channel_on;
  logic [5:0]  section_index;
  logic [13:0] pwm_position;
  int          n_fail = 0;
  int          n_compared = 0;
  ldcfg_top uut (.*);
  ldcfg_host host (.*);
  // 20 MHz clock
  always #25 aclk = ~aclk;
  //////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #3000000;
    n_fail++;
    print_verdict();
  end
  // Main sequence
  initial begin
    int cfg, nsec, slen, idx, k, ot, dly;
    void'($urandom(32'h6d9a296a));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      host.rd(4'(a), rd, resp);
      check("reset_reg", 32'h0, rd);
    end
    // Random words, reserved and low bits set on purpose
    repeat (6) begin
      cfg = $urandom & 32'hffff;
      host.wr(4'h0, 32'(cfg), resp);
      repeat (3) @(posedge aclk);
      check("rise", 32'(cfg[15]), output_rise_slew_select);
      check("fall", 32'(cfg[14]), output_fall_slew_select);
      check("lg1", 32'(cfg[8]), low_gray_comp1_en);
      host.rd(4'h0, rd, resp);
      check("cfg2", 32'(cfg & 32'hfd00), rd);
    end
    // Reset in mid-run returns every stored field and drive output to its default
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check("rst_out", 32'h0, {output_rise_slew_select, output_fall_slew_select,
                             low_gray_comp1_en});
    for (int a = 0; a < 12; a += 4) begin
      host.rd(4'(a), rd, resp);
      check("rst_reg", 32'h0, rd);
    end
    // Partial strobes: upper byte alone, then low byte alone
    host.wr(4'h0, 32'hffff, resp, 4'h2);
    host.rd(4'h0, rd, resp);
    check("cfg2_hi", 32'hfd00, rd);
    host.wr(4'h8, 32'h3fff, resp, 4'h1);
    host.rd(4'h8, rd, resp);
    check("probe_lo", 32'h00ff, rd);
    // All four depth and refresh combinations
    for (int m = 0; m < 4; m++) begin
      host.wr(4'h4, 32'(m & 1), resp);
      host.wr(4'h0, 32'((m >> 1) << 10), resp);
      host.rd(4'hc, rd, resp);
      slen = m[1] ? 256 : 512;
      nsec = (m[0] ? 8192 : 16384) / slen;
      check("sections", 32'(nsec - 1), rd[15:10]);
      check("depth", 32'(m & 1), rd[3]);
      do @(posedge aclk); while (section_start !== 1'b1);
      idx = section_index;
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (section_start !== 1'b1);
      check("sect_len", 32'(slen * 2), 32'(k));
      check("sect_idx", 32'((idx + 1) % nsec), section_index);
    end
    // Every shift code against short and long on-times
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 3; i++) begin
        ot = (i == 0) ? 1 : i + 3;
        host.wr(4'h0, 32'(c << 11), resp);
        host.wr(4'h8, 32'(ot), resp);
        host.rd(4'hc, rd, resp);
        dly = (ot <= 4) ? ((c > 5) ? 5 : c) : 0;
        check("delay", 32'(dly), rd[2:0]);
        if (c == 0) check("no_shift", 32'h0, rd[2:0]);
      end
    end
    // Shift code 3 with a 2-clock on-time: probe lights at positions 3 and 4
    host.wr(4'h0, 32'h1800, resp);
    host.wr(4'h8, 32'h2, resp);
    do @(posedge aclk); while (pwm_position !== 14'h0000);
    for (int p = 0; p < 8; p++) begin
      check("probe_pos", 32'(p), pwm_position);
      check("probe_on", 32'(p >= 3 && p < 5), probe_channel_on);
      repeat (2) @(posedge aclk);
    end
    // Read-only store and unaligned read are refused
    host.wr(4'hc, 32'hffff, resp);
    check("ro_write", 32'h2, resp);
    host.rd(4'h2, rd, resp);
    check("unaligned", 32'h2, resp);
    print_verdict();
  end
endmodule
